/* hw/alm_pkg.sv */
// package: constants and carrier types of the analog limit monitor
//
// Contract
// - limit checks only on result slots 0..5
// - compare all twelve result bits
// - twelve flags: high and low per slot
// - high flag when result >= upper limit
// - low flag when result <= lower limit
// - four comparators, own 6-bit reference code
// - each modulator gets one selected comparator
// - comparators watch channels two to five
// - hold reset 1 ms after supply good
// - droop trip raises processor interrupt
// - temperature sensor routed to channel 15
// - software enables or disables temperature sensor
// - channels 0,1 double as address inputs
// - results stored in time order, slots 0..15; code stores each result in the slot its write names, slots 0..5 only
package alm_pkg;
    // register word indices (byte address = index)
    localparam logic [7:0] ALM_LIM_BASE = 8'h00; // 0x00..0x0B: hi,lo pairs
    localparam logic [7:0] ALM_LIM_STATUS = 8'h10; // 12 limit flags, read only
    localparam logic [7:0] ALM_REF_BASE = 8'h14; // 0x14..0x17: comparator refs
    localparam logic [7:0] ALM_CLF_SEL = 8'h18; // 2 bits per modulator
    localparam logic [7:0] ALM_MISC_CTL = 8'h19; // bit0 temp sensor enable
    localparam logic [7:0] ALM_IRQ_STAT = 8'h1A; // sticky events, w1c
    localparam logic [7:0] ALM_IRQ_MASK = 8'h1B; // interrupt mask
    localparam logic [7:0] ALM_RAW_STAT = 8'h1C; // live comparator, reset state
    // sizes
    localparam int ALM_SLOTS = 6;
    localparam int ALM_RES_W = 12;
    localparam int ALM_REF_W = 6;
    localparam int ALM_NCMP = 4;
    localparam int ALM_TEMP_CH = 15;
    localparam int ALM_CMP_CH0 = 2; // first channel shared with comparators
    // reset values
    localparam logic [11:0] ALM_HI_RST = 12'hFFF;
    localparam logic [11:0] ALM_LO_RST = 12'h000;
    localparam logic [5:0] ALM_REF_RST = 6'h00;
    localparam logic [1:0] ALM_SEL_RST = 2'h0;
    // interrupt bits: 0 droop, 1 any high flag rose, 2 any low flag rose
    localparam int ALM_IRQ_W = 3;
    // timing
    localparam real ALM_CLK_MHZ = 40.0;
    localparam real ALM_POR_MS = 1.0;
    localparam int ALM_POR_CYC = int'(ALM_POR_MS * 1000.0 * ALM_CLK_MHZ);
    localparam real ALM_TSET_US = 100.0;
    localparam int ALM_TSET_CYC = int'(ALM_TSET_US * ALM_CLK_MHZ);
    // result write from the sequencer
    typedef struct packed {
        logic vld;
        logic [3:0] slot;
        logic [11:0] data;
    } alm_res_t;
    // reset sequencer states
    typedef enum logic [2:0] {
        ALM_HOLD = 3'b001,
        ALM_WAIT = 3'b010,
        ALM_RUN = 3'b100
    } alm_rst_st_t;
endpackage

/* hw/alm_top.sv */
// module: limit comparators, comparator routing, reset release and interrupts
`timescale 1ns/1ps
module alm_top #(
    parameter int NPWM = 8, // number of modulators fed
    parameter int POR_CYC = alm_pkg::ALM_POR_CYC // reset release delay
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic supply_good_i, // power good from supply monitor
    input wire logic ext_rst_n_i, // external reset pin, low active
    input wire logic supply_droop_detect_i, // droop comparator level
    input wire alm_pkg::alm_res_t res_i, // sequencer result write
    input wire logic [3:0] cmp_raw_i, // analog comparators on ch 2..5
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    output logic internal_reset_signal_o, // high while logic held
    output logic [NPWM-1:0] current_limit_flag_input_o,
    output logic [23:0] cmp_ref_o, // four 6-bit reference codes
    output logic temp_en_o, // temperature sensor enable
    output logic [4:0] temp_sensor_channel_o, // sensor's converter channel
    output logic [1:0] addr_id_ch_o // channels holding address pins
);
    // whole state of the block
    typedef struct packed {
        logic [5:0][11:0] hi;
        logic [5:0][11:0] lo;
        logic [5:0][11:0] res;
        logic [5:0] fhi;
        logic [5:0] flo;
        logic [3:0][5:0] ref_c;
        logic [NPWM-1:0][1:0] sel;
        logic [NPWM-1:0] current_limit_flag_input;
        logic ten;
        logic [2:0] ist;
        logic [2:0] imsk;
        logic irq;
        logic droop_q;
        logic hold; // held flag kept in a flop for the reset pin
        alm_pkg::alm_rst_st_t st;
        logic [31:0] cnt;
        logic [31:0] rdata;
    } alm_st_t;

    alm_st_t s_q;
    alm_st_t s_d;

    // selects one comparator for a modulator
    function automatic logic pick(input logic [3:0] c, input logic [1:0] k);
        pick = c[k];
    endfunction

    // next state
    always_comb
    begin
        logic [5:0] nhi;
        logic [5:0] nlo;
        int idx;
        nhi = '0;
        nlo = '0;
        idx = 0;
        s_d = s_q;
        s_d.rdata = 32'h0;
        // register writes
        if (wr_i)
        begin
            if (addr_i < 8'h0C)
            begin
                idx = int'(addr_i[7:1]);
                if (addr_i[0])
                    s_d.lo[idx] = wdata_i[11:0];
                else
                    s_d.hi[idx] = wdata_i[11:0];
            end
            else if (addr_i[7:2] == alm_pkg::ALM_REF_BASE[7:2])
                s_d.ref_c[addr_i[1:0]] = wdata_i[5:0];
            else if (addr_i == alm_pkg::ALM_CLF_SEL)
                s_d.sel = wdata_i[2*NPWM-1:0];
            else if (addr_i == alm_pkg::ALM_MISC_CTL)
                s_d.ten = wdata_i[0];
            else if (addr_i == alm_pkg::ALM_IRQ_MASK)
                s_d.imsk = wdata_i[2:0];
        end
        // store results in their own slot; only slots 0..5 kept
        if (res_i.vld && res_i.slot < 4'h6)
            s_d.res[res_i.slot[2:0]] = res_i.data;
        // full 12-bit compare against limits
        for (int i = 0; i < alm_pkg::ALM_SLOTS; i++)
        begin
            nhi[i] = s_d.res[i] >= s_d.hi[i];
            nlo[i] = s_d.res[i] <= s_d.lo[i];
        end
        s_d.fhi = nhi;
        s_d.flo = nlo;
        // routing to current limit flags
        for (int p = 0; p < NPWM; p++)
            s_d.current_limit_flag_input[p] = pick(cmp_raw_i, s_q.sel[p]);
        // sticky events: clear by writing one, set wins
        if (wr_i && addr_i == alm_pkg::ALM_IRQ_STAT)
            s_d.ist = s_q.ist & ~wdata_i[2:0];
        s_d.droop_q = supply_droop_detect_i;
        if (supply_droop_detect_i && !s_q.droop_q)
            s_d.ist[0] = 1'b1;
        if (|(nhi & ~s_q.fhi))
            s_d.ist[1] = 1'b1;
        if (|(nlo & ~s_q.flo))
            s_d.ist[2] = 1'b1;
        s_d.irq = |(s_d.ist & s_d.imsk);
        // reset release sequencer
        unique case (s_q.st)
            alm_pkg::ALM_HOLD:
            begin
                s_d.cnt = 32'h0;
                if (supply_good_i && ext_rst_n_i)
                    s_d.st = alm_pkg::ALM_WAIT;
            end
            alm_pkg::ALM_WAIT:
            begin
                if (!(supply_good_i && ext_rst_n_i))
                    s_d.st = alm_pkg::ALM_HOLD;
                else if (s_q.cnt == 32'(POR_CYC - 1))
                    s_d.st = alm_pkg::ALM_RUN;
                else
                    s_d.cnt = s_q.cnt + 32'h1;
            end
            alm_pkg::ALM_RUN:
            begin
                if (!(supply_good_i && ext_rst_n_i))
                    s_d.st = alm_pkg::ALM_HOLD;
            end
            default: s_d.st = alm_pkg::ALM_HOLD;
        endcase
        // internal reset pin follows the next state, so it leaves a flop
        s_d.hold = s_d.st != alm_pkg::ALM_RUN;
        // reads answer in the next cycle; unmapped reads zero
        if (rd_i)
        begin
            if (addr_i < 8'h0C)
                s_d.rdata = {20'h0, addr_i[0] ? s_q.lo[addr_i[7:1]]
                                              : s_q.hi[addr_i[7:1]]};
            else if (addr_i[7:2] == alm_pkg::ALM_REF_BASE[7:2])
                s_d.rdata = {26'h0, s_q.ref_c[addr_i[1:0]]};
            else if (addr_i == alm_pkg::ALM_LIM_STATUS)
                s_d.rdata = {20'h0, s_q.flo, s_q.fhi};
            else if (addr_i == alm_pkg::ALM_CLF_SEL)
                s_d.rdata = 32'(s_q.sel);
            else if (addr_i == alm_pkg::ALM_MISC_CTL)
                s_d.rdata = {31'h0, s_q.ten};
            else if (addr_i == alm_pkg::ALM_IRQ_STAT)
                s_d.rdata = {29'h0, s_q.ist};
            else if (addr_i == alm_pkg::ALM_IRQ_MASK)
                s_d.rdata = {29'h0, s_q.imsk};
            else if (addr_i == alm_pkg::ALM_RAW_STAT)
                s_d.rdata = {26'h0, s_q.st == alm_pkg::ALM_RUN,
                             supply_droop_detect_i, cmp_raw_i};
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_q <= '0;
            s_q.hi <= {6{alm_pkg::ALM_HI_RST}};
            s_q.lo <= {6{alm_pkg::ALM_LO_RST}};
            s_q.res <= {6{12'h800}};
            s_q.st <= alm_pkg::ALM_HOLD;
            s_q.hold <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // outputs straight from flops; sensor and address channel outputs are constants
    assign rdata_o = s_q.rdata;
    assign irq_o = s_q.irq;
    assign internal_reset_signal_o = s_q.hold;
    assign current_limit_flag_input_o = s_q.current_limit_flag_input;
    assign cmp_ref_o = s_q.ref_c;
    assign temp_en_o = s_q.ten;
    assign temp_sensor_channel_o = 5'(alm_pkg::ALM_TEMP_CH);
    assign addr_id_ch_o = 2'h0; // channel 0 addr pin 1, ch 1 pin 2

    // assertions: flags, result slots, routing, references, reset release, events and sensor
    // high flag of slot 0 follows its stored result and limit
    high_flag_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        s_q.fhi[0] == (s_q.res[0] >= s_q.hi[0]))
        else $error("high flag wrong");

    // high flag of the last monitored slot
    high_last_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        s_q.fhi[5] == (s_q.res[5] >= s_q.hi[5]))
        else $error("last high flag wrong");

    // low flag of the last monitored slot
    low_flag_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        s_q.flo[5] == (s_q.res[5] <= s_q.lo[5]))
        else $error("low flag wrong");

    // low flag of slot 0
    low_first_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        s_q.flo[0] == (s_q.res[0] <= s_q.lo[0]))
        else $error("first low flag wrong");

    // a result for slot 2 lands whole in slot 2
    slot_store_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        res_i.vld && res_i.slot == 4'h2 |=> s_q.res[2] == $past(res_i.data))
        else $error("result not stored");

    // results for slots 6..15 leave the stored results alone
    slot_six_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        res_i.vld && res_i.slot > 4'h5 |=> $stable(s_q.res))
        else $error("late slot stored");

    // a new upper limit is compared at once
    limit_write_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        wr_i && addr_i == alm_pkg::ALM_LIM_BASE |=>
            s_q.fhi[0] == (s_q.res[0] >= $past(wdata_i[11:0])))
        else $error("limit change not applied");

    // modulator 0 sees the comparator its select names
    route_sel_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        ##1 current_limit_flag_input_o[0] ==
            $past(cmp_raw_i[s_q.sel[0]]))
        else $error("route wrong");

    // a select write takes effect in the next cycle
    sel_write_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        wr_i && addr_i == alm_pkg::ALM_CLF_SEL |=>
            s_q.sel == $past(wdata_i[2*NPWM-1:0]))
        else $error("select write lost");

    // reference code 0 follows its register write
    ref_write_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        wr_i && addr_i == alm_pkg::ALM_REF_BASE |=>
            cmp_ref_o[5:0] == $past(wdata_i[5:0]))
        else $error("reference write lost");

    // a droop edge always latches its event bit
    droop_irq_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        $rose(supply_droop_detect_i) |=> s_q.ist[0])
        else $error("droop not latched");

    // the droop bit stays until software writes a one to it
    droop_keep_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        s_q.ist[0] && !(wr_i && addr_i == alm_pkg::ALM_IRQ_STAT
            && wdata_i[0]) |=> s_q.ist[0])
        else $error("droop event lost");

    // an unmasked droop event drives the interrupt line
    irq_level_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        s_q.ist[0] && s_q.imsk[0] |-> irq_o)
        else $error("irq not raised");

    // no unmasked event, no interrupt
    irq_quiet_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !(|(s_q.ist & s_q.imsk)) |-> !irq_o)
        else $error("irq without cause");

    // a lost supply puts the logic back into reset
    rst_hold_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !supply_good_i |=> internal_reset_signal_o)
        else $error("reset released early");

    // a pulled external reset does the same
    ext_hold_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !ext_rst_n_i |=> internal_reset_signal_o)
        else $error("external reset ignored");

    // the logic stays held until the sequencer runs
    rel_hold_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        s_q.st != alm_pkg::ALM_RUN |-> internal_reset_signal_o)
        else $error("hold output wrong");

    // the release counter never passes its end point
    rst_count_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        s_q.st == alm_pkg::ALM_WAIT |-> s_q.cnt < 32'(POR_CYC))
        else $error("reset delay overrun");

    // sensor enable follows its control bit
    ten_ctl_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        wr_i && addr_i == alm_pkg::ALM_MISC_CTL |=>
            temp_en_o == $past(wdata_i[0]))
        else $error("sensor enable wrong");

    // the sensor stays on its fixed converter channel
    temp_ch_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        temp_sensor_channel_o == 5'(alm_pkg::ALM_TEMP_CH))
        else $error("sensor channel wrong");

    // main scenarios: release, flag rises, droop event, interrupt
    cov_rel: cover property (@(posedge clk_i) $fell(internal_reset_signal_o));
    cov_hi: cover property (@(posedge clk_i) $rose(s_q.fhi[0]));
    cov_lo: cover property (@(posedge clk_i) $rose(s_q.flo[0]));
    cov_droop: cover property (@(posedge clk_i) $rose(s_q.ist[0]));
    cov_irq: cover property (@(posedge clk_i) $rose(irq_o));
endmodule // alm_top

/* bench/alm_seq_model.sv */
// partner model: sequencer result writes and comparator levels
`timescale 1ns/1ps
module alm_seq_model (
    input wire logic clk_i,
    output alm_pkg::alm_res_t res_o, // result write toward the block
    output logic [3:0] cmp_o // comparators on channels 2..5
);
    // idle: no write, no comparator tripped
    initial
    begin
        res_o = '0;
        cmp_o = 4'h0;
    end
    // one result write, one cycle, into the slot the caller names
    task automatic put(input logic [3:0] slot, input logic [11:0] data);
        @(posedge clk_i);
        res_o <= '{vld: 1'b1, slot: slot, data: data};
        @(posedge clk_i);
        res_o.vld <= 1'b0;
        res_o.data <= ~data; // stale data must not look valid
    endtask
    // new comparator levels after an edge
    task automatic set_cmp(input logic [3:0] v);
        @(posedge clk_i);
        cmp_o <= v;
    endtask
endmodule // alm_seq_model

/* bench/test_analog_limit_monitor.sv */
// testbench: limits, routing, reset release, interrupts
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    n_errors++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module test_analog_limit_monitor;
    localparam int POR = 20; // shortened release delay
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic supply_good_i = 1'b0;
    logic ext_rst_n_i = 1'b0;
    logic droop = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rd_q = 1'b0;
    alm_pkg::alm_res_t res;
    logic [3:0] cmp;
    logic [31:0] rdata_o, e_w;
    logic irq_o, irst, temp_en_o;
    logic [7:0] current_limit_flag_input;
    logic [23:0] cmp_ref_o, refs;
    logic [4:0] tch;
    logic [1:0] aid;
    logic [11:0] hi_m [6], lo_m [6], res_m [6], v;
    logic [31:0] exp_q [$];
    logic [15:0] sel;
    int n_errors = 0, check_count = 0, n;
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    alm_top #(.NPWM(8), .POR_CYC(POR)) alm_top_inst (.clk_i(clk_i),
        .nrst_i(nrst_i), .supply_good_i(supply_good_i),
        .ext_rst_n_i(ext_rst_n_i), .supply_droop_detect_i(droop),
        .res_i(res), .cmp_raw_i(cmp), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
        .internal_reset_signal_o(irst), .current_limit_flag_input_o(current_limit_flag_input),
        .cmp_ref_o(cmp_ref_o), .temp_en_o(temp_en_o),
        .temp_sensor_channel_o(tch), .addr_id_ch_o(aid));
    alm_seq_model alm_seq_model_inst (.clk_i(clk_i), .res_o(res),
        .cmp_o(cmp));
    // scoreboard: read data stand only in the cycle after the strobe
    always @(posedge clk_i) rd_q <= rd_i;
    always @(negedge clk_i)
    begin
        if (rd_q && exp_q.size() > 0)
        begin
            e_w = exp_q.pop_front();
            `CHK(rdata_o, e_w)
        end
    end
    task automatic tally_and_finish();
        $display("TB: errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // one-cycle read strobe, expectation noted for the scoreboard
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    // count cycles until the logic is let go, bounded
    task automatic rel_wait();
        n = 0;
        while (irst === 1'b1 && n < 100)
        begin
            @(negedge clk_i);
            n++;
        end
        `CHK(n >= POR && n <= POR + 3, 1'b1)
        if (n >= 100) tally_and_finish();
    endtask
    // expected flags from the bench's own copy of limits and results
    function automatic logic [31:0] flags();
        logic [31:0] f;
        f = '0;
        for (int i = 0; i < 6; i++)
        begin
            f[i] = res_m[i] >= hi_m[i];
            f[6 + i] = res_m[i] <= lo_m[i];
        end
        return f;
    endfunction
    initial
    begin
        void'($urandom(32'hBCF0));
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        settle(10);
        `CHK(irst, 1'b1)
        @(posedge clk_i);
        supply_good_i <= 1'b1;
        ext_rst_n_i <= 1'b1;
        rel_wait();
        @(posedge clk_i);
        ext_rst_n_i <= 1'b0;
        settle(3);
        `CHK(irst, 1'b1)
        @(posedge clk_i);
        ext_rst_n_i <= 1'b1;
        rel_wait();
        rd(8'h00, 32'hFFF);
        rd(8'h01, 32'h0);
        rd(alm_pkg::ALM_CLF_SEL, 32'h0);
        rd(8'h30, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            hi_m[i] = 12'hFFF;
            lo_m[i] = 12'h000;
            res_m[i] = 12'h800;
        end
        // slot 6 reuses slot 0 values and must change nothing
        for (int i = 0; i < 7; i++)
        begin
            if (i < 6)
            begin
                hi_m[i] = 12'($urandom);
                lo_m[i] = 12'($urandom);
                wr(8'(2 * i), {20'h0, hi_m[i]});
                wr(8'(2 * i + 1), {20'h0, lo_m[i]});
            end
            for (int k = 0; k < 3; k++)
            begin
                v = k == 0 ? hi_m[i % 6] : k == 1 ? lo_m[i % 6]
                    : 12'($urandom);
                alm_seq_model_inst.put(4'(i), v);
                if (i < 6) res_m[i] = v;
                rd(alm_pkg::ALM_LIM_STATUS, flags());
            end
        end
        // fresh rises of a high and a low flag set their event bits
        wr(8'h00, 32'hFFF);
        wr(8'h01, 32'h0);
        alm_seq_model_inst.put(4'h0, 12'h001);
        wr(alm_pkg::ALM_IRQ_STAT, 32'h7);
        wr(8'h00, 32'h0);
        wr(8'h01, 32'h1);
        rd(alm_pkg::ALM_IRQ_STAT, 32'h6);
        wr(alm_pkg::ALM_IRQ_STAT, 32'h7);
        rd(alm_pkg::ALM_IRQ_STAT, 32'h0);
        droop <= 1'b1;
        rd(alm_pkg::ALM_IRQ_STAT, 32'h1);
        settle(1);
        `CHK(irq_o, 1'b0)
        wr(alm_pkg::ALM_IRQ_MASK, 32'h1);
        settle(2);
        `CHK(irq_o, 1'b1)
        wr(alm_pkg::ALM_IRQ_STAT, 32'h1);
        settle(2);
        `CHK(irq_o, 1'b0)
        sel = 16'($urandom);
        wr(alm_pkg::ALM_CLF_SEL, {16'h0, sel});
        for (int c = 0; c < 16; c++)
        begin
            alm_seq_model_inst.set_cmp(4'(c));
            settle(2);
            for (int p = 0; p < 8; p++)
                `CHK(current_limit_flag_input[p], cmp[sel[2*p +: 2]])
        end
        // live view: released, droop still high, all comparators set
        rd(alm_pkg::ALM_RAW_STAT, 32'h3F);
        refs = 24'($urandom);
        for (int k = 0; k < 4; k++)
            wr(8'(alm_pkg::ALM_REF_BASE + k), {26'h0, refs[6*k +: 6]});
        settle(1);
        `CHK(cmp_ref_o, refs)
        rd(alm_pkg::ALM_REF_BASE + 8'h03, {26'h0, refs[23:18]});
        wr(alm_pkg::ALM_MISC_CTL, 32'h1);
        repeat (4000) @(posedge clk_i);
        settle(1);
        `CHK(temp_en_o, 1'b1)
        `CHK(tch, 5'h0F)
        `CHK(aid, 2'h0)
        wr(alm_pkg::ALM_MISC_CTL, 32'h0);
        settle(2);
        `CHK(temp_en_o, 1'b0)
        tally_and_finish();
    end
endmodule // test_analog_limit_monitor
